// File: verilog/cantx_pkg.sv
// Package for the CAN transceiver mode and dominant-timeout control.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package cantx_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    // Legal dominant run: eleven bits at the slowest legal rate
    localparam int unsigned MAX_DOM_BITS    = 11;
    localparam int unsigned MIN_BIT_RATE    = 60_000;
    localparam int unsigned MAX_BIT_RATE    = 1_000_000;
    // Timeout in microseconds, kept above 11 bits at 60 kbit/s (183.3 us)
    localparam int unsigned DOM_TIMEOUT_US  = 300;
    localparam int unsigned DOM_TIMEOUT_CYC = (CLK_HZ / 1_000_000) * DOM_TIMEOUT_US;
    localparam int unsigned TO_CNT_W        = 16;

    // ------------------------------------------------------------------
    // Levels
    // ------------------------------------------------------------------
    localparam logic DOMINANT  = 1'b0;
    localparam logic RECESSIVE = 1'b1;

    // Synchronised pin view
    typedef struct packed {
        logic txd;
        logic silent;
        logic bus;
    } cantx_pins_t;

    // Idle levels: recessive data and bus, normal mode
    localparam cantx_pins_t PIN_IDLE = '{txd: RECESSIVE, silent: 1'b0, bus: RECESSIVE};

endpackage : cantx_pkg

// File: verilog/cantx_sync3.sv
// Three-flop synchroniser for the pin inputs with agreement filter.
// Assumes the pins are asynchronous to clk; reset value chosen per bit.
`timescale 1ns/1ps
module cantx_sync3 import cantx_pkg::*; #(
    parameter int          W        = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Pins and filtered result
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } cantx_sync_st_t;

    cantx_sync_st_t st;
    cantx_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Change taken only once stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;

endmodule : cantx_sync3

// File: verilog/cantx_ctrl.sv
// Mode control and dominant-timeout guard of a high-speed CAN transceiver.
// Assumes pins arrive asynchronously; pad pulls are resolved here from the open-pin indicators.
//
// Operation
// - A low mode-select level gives normal operation, driving the bus from transmit data.
// - An unconnected mode-select input is pulled low so normal operation is the default.
// - A high mode-select level selects silent operation.
// - While silent the driver stays off whatever transmit data shows.
// - Silent operation behaves as a non-transmitting node with the driver recessive.
// - While silent the receive output still follows the bus.
// - Transmit data dominant longer than the timeout disables the driver.
// - After a timeout the driver stays off until transmit data returns recessive.
// - An open transmit data input is pulled high, keeping the driver passive.
// - Low transmit data drives dominant, high leaves recessive, dominant wins on the bus.
// - The receiver always runs and presents the bus level, even while transmitting.
`timescale 1ns/1ps
module cantx_ctrl import cantx_pkg::*; #(
    parameter int unsigned TIMEOUT_CYC = DOM_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Controller side
    input  wire logic txd,
    output logic      rxd,
    // Mode pin, high selects silent
    input  wire logic silent_sel,
    // Pad pull indicators: high while pin floats
    input  wire logic txd_open,
    input  wire logic silent_sel_open,
    // Bus side: wired-AND level and driver enable
    input  wire logic bus_level,
    output logic      drv_en,
    // Status
    output logic      timeout_flag,
    output logic      silent_active
);
    // ------------------------------------------------------------------
    // Pad pulls and synchronisers
    // ------------------------------------------------------------------
    cantx_pins_t pin_raw;
    cantx_pins_t pin;

    always_comb begin
        pin_raw.txd    = txd_open ? RECESSIVE : txd;
        pin_raw.silent = silent_sel_open ? 1'b0 : silent_sel;
        pin_raw.bus    = bus_level;
    end

    // Idle pin levels at reset, so no false edge follows release
    cantx_sync3 #(
        .W       (3),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (pin_raw),
        .dout (pin)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [TO_CNT_W-1:0] cnt;
        logic                tout;
        logic                drv;
        logic                rx;
        logic                sil;
    } cantx_st_t;

    cantx_st_t st;
    cantx_st_t next_st;

    // Must exceed eleven bits at the slowest legal rate, or legal frames trip it
    localparam logic [TO_CNT_W-1:0] TERM = TO_CNT_W'(TIMEOUT_CYC);

    always_comb begin
        next_st = st;
        // Counter restarts on every recessive sample
        // Runs in silent mode too, so a stuck controller is still flagged
        if (pin.txd == RECESSIVE) begin
            next_st.cnt  = '0;
            next_st.tout = 1'b0;
        end else if (st.cnt != TERM) begin
            next_st.cnt = st.cnt + TO_CNT_W'(1);
        end else begin
            next_st.tout = 1'b1;
        end
        // Latch clears only on recessive, so only a fresh low drives again
        // Mode mirrored for status
        next_st.sil = pin.silent;
        next_st.drv = !pin.silent && !next_st.tout
                      && (pin.txd == DOMINANT);
        // Receiver independent of mode and driver
        next_st.rx  = pin.bus;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{cnt: '0, tout: 1'b0, drv: 1'b0, rx: RECESSIVE, sil: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign drv_en        = st.drv;
    assign rxd           = st.rx;
    assign timeout_flag  = st.tout;
    assign silent_active = st.sil;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_SILENT_NO_DRIVE: assert property (@(posedge clk) disable iff (rst)
        pin.silent |=> !drv_en) else $error("driver on while silent");

    AST_NORMAL_DRIVES: assert property (@(posedge clk) disable iff (rst)
        !pin.silent && pin.txd == DOMINANT && !next_st.tout |=> drv_en)
        else $error("normal mode did not drive dominant");

    AST_RECESSIVE_OFF: assert property (@(posedge clk) disable iff (rst)
        pin.txd == RECESSIVE |=> !drv_en) else $error("driver on for recessive data");

    AST_RX_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> rxd == $past(pin.bus)) else $error("receive output lost the bus");

    AST_RX_SILENT: assert property (@(posedge clk) disable iff (rst)
        silent_active |-> rxd == $past(pin.bus)) else $error("no listening while silent");

    AST_TIMEOUT_TRIP: assert property (@(posedge clk) disable iff (rst)
        st.cnt == TERM && pin.txd == DOMINANT |=> timeout_flag && !drv_en)
        else $error("timeout did not disable driver");

    AST_TIMEOUT_HOLD: assert property (@(posedge clk) disable iff (rst)
        timeout_flag && pin.txd == DOMINANT |=> timeout_flag && !drv_en)
        else $error("driver returned before release");

    AST_CNT_CLEAR: assert property (@(posedge clk) disable iff (rst)
        pin.txd == RECESSIVE |=> st.cnt == '0 && !timeout_flag)
        else $error("counter not cleared on recessive");

    AST_SHORT_RUN: assert property (@(posedge clk) disable iff (rst)
        drv_en |-> !$past(pin.silent) && !timeout_flag && $past(pin.txd) == DOMINANT)
        else $error("enable not gated by mode, latch and data");

    AST_MODE_MIRROR: assert property (@(posedge clk) disable iff (rst)
        pin.silent ##1 pin.silent |-> silent_active) else $error("silent not reported");

    // ------------------------------------------------------------------
    // Pin to output checks, two agreeing samples then four edges, except the same-cycle silent passive check
    // ------------------------------------------------------------------
    AST_PULL_DOWN_DEFAULT: assert property (@(posedge clk) disable iff (rst)
        silent_sel_open [*2] |-> ##4 !silent_active)
        else $error("open mode pin did not give normal mode");

    AST_NORMAL_PIN_MODE: assert property (@(posedge clk) disable iff (rst)
        (!silent_sel || silent_sel_open) [*2] |-> ##4 !silent_active)
        else $error("low mode pin did not give normal mode");

    AST_SILENT_PIN_MODE: assert property (@(posedge clk) disable iff (rst)
        (silent_sel && !silent_sel_open) [*2] |-> ##4 silent_active)
        else $error("high mode pin did not give silent mode");

    AST_SILENT_PIN_OFF: assert property (@(posedge clk) disable iff (rst)
        (silent_sel && !silent_sel_open) [*2] |-> ##4 !drv_en)
        else $error("driver on after high mode pin");

    AST_SILENT_PASSIVE: assert property (@(posedge clk) disable iff (rst)
        silent_active |-> !drv_en)
        else $error("silent node not passive");

    AST_PULL_UP_PASSIVE: assert property (@(posedge clk) disable iff (rst)
        txd_open [*2] |-> ##4 !drv_en)
        else $error("open data pin drove the bus");

    AST_DOM_PIN_DRIVES: assert property (@(posedge clk) disable iff (rst)
        (txd == DOMINANT && !txd_open && !silent_sel) [*2] |-> ##4 (drv_en || timeout_flag))
        else $error("low data pin did not drive dominant");

    AST_RX_PIN_LOW: assert property (@(posedge clk) disable iff (rst)
        !bus_level [*2] |-> ##4 !rxd)
        else $error("dominant bus not received");

    AST_RX_PIN_HIGH: assert property (@(posedge clk) disable iff (rst)
        bus_level [*2] |-> ##4 rxd)
        else $error("recessive bus not received");

    AST_RX_SILENT_PIN: assert property (@(posedge clk) disable iff (rst)
        (silent_sel && !silent_sel_open && !bus_level) [*2] |-> ##4 !rxd)
        else $error("silent node deaf to dominant bus");

    // ------------------------------------------------------------------
    // Timeout counter and latch checks
    // ------------------------------------------------------------------
    AST_CNT_BOUND: assert property (@(posedge clk) disable iff (rst)
        st.cnt <= TERM)
        else $error("timeout counter passed terminal count");

    AST_CNT_STEP: assert property (@(posedge clk) disable iff (rst)
        pin.txd == DOMINANT && st.cnt != TERM |=> st.cnt == $past(st.cnt) + TO_CNT_W'(1))
        else $error("timeout counter did not step");

    AST_CNT_HOLD_TERM: assert property (@(posedge clk) disable iff (rst)
        st.cnt == TERM && pin.txd == DOMINANT |=> st.cnt == TERM)
        else $error("timeout counter wrapped");

    AST_DRV_COUNTED: assert property (@(posedge clk) disable iff (rst)
        drv_en |-> st.cnt != '0 && !timeout_flag)
        else $error("drive not covered by the timeout counter");

    AST_TOUT_DRIVER_OFF: assert property (@(posedge clk) disable iff (rst)
        timeout_flag |-> !drv_en)
        else $error("driver on during timeout");

    AST_TOUT_SET_AT_TERM: assert property (@(posedge clk) disable iff (rst)
        $rose(timeout_flag) |-> $past(st.cnt) == TERM)
        else $error("timeout raised before terminal count");

    AST_TOUT_RELEASE: assert property (@(posedge clk) disable iff (rst)
        timeout_flag && pin.txd == RECESSIVE |=> !timeout_flag)
        else $error("timeout not released by recessive data");

    AST_FRESH_LOW: assert property (@(posedge clk) disable iff (rst)
        $fell(timeout_flag) |-> !drv_en)
        else $error("driver on at timeout release");

endmodule : cantx_ctrl

// File: bench/cantx_partner.sv
// Model of the protocol controller and the wired-AND bus beside the transceiver.
// Assumes the bench sets controller intent and remote traffic at rising edges.
`timescale 1ns/1ps
module cantx_partner (
    // Intent from the bench
    input  wire logic want_dom,
    input  wire logic remote_dom,
    // Transceiver side
    input  wire logic drv_en,
    output logic      txd,
    output logic      bus_level
);
    // Low means dominant; a legal controller keeps runs short
    assign txd = ~want_dom;
    // Any dominant driver wins over recessive
    assign bus_level = ~(drv_en | remote_dom);
endmodule : cantx_partner

// File: bench/can_transceiver_mode_timeout_ctrl_tb_top.sv
// Self-checking bench for the transceiver mode and timeout control.
// Assumes a shortened timeout of 20 cycles and four cycles of pin latency.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %b got %b", nm, e, g); end end
module can_transceiver_mode_timeout_ctrl_tb_top import cantx_pkg::*;;
    logic clk = 0, rst = 1, want_dom = 0, remote_dom = 0;
    logic sel = 0, txd_open = 0, sel_open = 0;
    logic txd, rxd, bus_level, drv_en, tflag, sil;
    int   n_mismatch = 0, total_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    cantx_ctrl #(.TIMEOUT_CYC(20)) i_dut (.clk(clk), .rst(rst), .txd(txd), .rxd(rxd),
        .silent_sel(sel), .txd_open(txd_open), .silent_sel_open(sel_open),
        .bus_level(bus_level), .drv_en(drv_en), .timeout_flag(tflag), .silent_active(sil));
    cantx_partner i_partner (.want_dom(want_dom), .remote_dom(remote_dom), .drv_en(drv_en),
        .txd(txd), .bus_level(bus_level));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : wt
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_normal;
        @(posedge clk) want_dom <= 1;
        wt(10);
        `CHK("drv_en", 1'b1, drv_en)
        `CHK("rxd", 1'b0, rxd)
        @(posedge clk) want_dom <= 0;
        wt(10);
        `CHK("drv_en", 1'b0, drv_en)
        `CHK("rxd", 1'b1, rxd)
    endtask : t_normal
    task automatic t_pulls;
        @(posedge clk) begin sel <= 1; sel_open <= 1; want_dom <= 1; end
        wt(10);
        `CHK("silent_active", 1'b0, sil)
        `CHK("drv_en", 1'b1, drv_en)
        @(posedge clk) begin txd_open <= 1; sel <= 0; sel_open <= 0; end
        wt(10);
        `CHK("drv_en", 1'b0, drv_en)
        @(posedge clk) begin txd_open <= 0; want_dom <= 0; end
        wt(8);
    endtask : t_pulls
    task automatic t_silent;
        @(posedge clk) begin want_dom <= 1; sel <= 1; end
        wt(10);
        `CHK("silent_active", 1'b1, sil)
        `CHK("drv_en", 1'b0, drv_en)
        `CHK("rxd", 1'b1, rxd)
        @(posedge clk) remote_dom <= 1;
        wt(10);
        `CHK("rxd", 1'b0, rxd)
        `CHK("timeout_flag", 1'b0, tflag)
        @(posedge clk) begin remote_dom <= 0; sel <= 0; want_dom <= 0; end
        wt(10);
    endtask : t_silent
    task automatic t_timeout;
        @(posedge clk) want_dom <= 1;
        wt(18);
        `CHK("drv_en", 1'b1, drv_en)
        `CHK("timeout_flag", 1'b0, tflag)
        wt(20);
        `CHK("timeout_flag", 1'b1, tflag)
        `CHK("drv_en", 1'b0, drv_en)
        @(posedge clk) want_dom <= 0;
        wt(10);
        `CHK("timeout_flag", 1'b0, tflag)
        @(posedge clk) want_dom <= 1;
        wt(10);
        `CHK("drv_en", 1'b1, drv_en)
        @(posedge clk) want_dom <= 0;
        wt(10);
    endtask : t_timeout
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        wt(6);
        `CHK("drv_en", 1'b0, drv_en)
        `CHK("run_fit", 1'b1, MAX_DOM_BITS * (CLK_HZ / MIN_BIT_RATE) < DOM_TIMEOUT_CYC)
        t_normal();
        t_pulls();
        t_silent();
        t_timeout();
        report_and_stop();
    end
endmodule : can_transceiver_mode_timeout_ctrl_tb_top
